// File: design/ats_delay_pkg.sv
package ats_delay_pkg;
	// Timebase
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned TICK_PERIOD_NS = 1_000_000_000;
	localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// Width of every delay setting, in seconds
	localparam int unsigned SET_W = 12;

	// Timer channel indices
	localparam int unsigned T_SHED = 0;
	localparam int unsigned T_COOL = 1;
	localparam int unsigned T_FAIL = 2;
	localparam int unsigned T_ON_TEST = 3;
	localparam int unsigned T_OFF_TEST = 4;
	localparam int unsigned N_TIMERS = 5;

	// Setting write addresses
	localparam logic [2:0] ADDR_SHED = 3'h0;
	localparam logic [2:0] ADDR_COOL = 3'h1;
	localparam logic [2:0] ADDR_FAIL = 3'h2;
	localparam logic [2:0] ADDR_ON_TEST = 3'h3;
	localparam logic [2:0] ADDR_OFF_TEST = 3'h4;
	localparam logic [2:0] ADDR_ALARM_EN = 3'h5;
	localparam logic [2:0] ADDR_ON_LIMITED = 3'h6;
	localparam logic [2:0] ADDR_OFF_LIMITED = 3'h7;

	// Values after reset, limits, in seconds
	localparam logic [SET_W-1:0] SHED_DEFAULT = 12'h000;
	localparam logic [SET_W-1:0] SHED_MAX = 12'h00F;
	localparam logic [SET_W-1:0] COOL_DEFAULT = 12'h03C;
	localparam logic [SET_W-1:0] COOL_MAX = 12'hE10;
	localparam logic [SET_W-1:0] FAIL_DEFAULT = 12'h12C;
	localparam logic [SET_W-1:0] FAIL_MIN = 12'h00F;
	localparam logic [SET_W-1:0] FAIL_MAX = 12'h12C;
	localparam logic [SET_W-1:0] TEST_UNLIMITED = 12'h000;
	localparam logic [SET_W-1:0] TEST_LIMITED_DEFAULT = 12'h01E;
	localparam logic [SET_W-1:0] TEST_MAX = 12'h708;
	localparam logic ALARM_EN_DEFAULT = 1'b0;
endpackage

// File: design/second_tick.sv
`timescale 1ns/1ps
module second_tick #(
	parameter int unsigned TICK_CYCLES = ats_delay_pkg::TICK_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	output logic o_tick
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} state_s;

	state_s cur;
	state_s next_cur;

	always_comb begin
		next_cur = cur;
		next_cur.tick = 1'b0;
		if (cur.cnt >= TICK_CYCLES - 1) begin
			next_cur.cnt = 32'h00000000;
			next_cur.tick = 1'b1;
		end else begin
			next_cur.cnt = cur.cnt + 32'h00000001;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign o_tick = cur.tick;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);

	property p_tick_single;
		o_tick |=> !o_tick;
	endproperty
	a_tick_single: assert property (p_tick_single) else $error("tick lasted more than one cycle");
endmodule

// File: design/second_timer.sv
`timescale 1ns/1ps
module second_timer #(
	parameter int unsigned W = ats_delay_pkg::SET_W
) (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic i_tick,
	input wire logic i_run,
	input wire logic [W-1:0] i_load,
	output logic o_expired,
	output logic [W-1:0] o_remaining
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic expired;
	} state_s;

	state_s cur;
	state_s next_cur;

	always_comb begin
		next_cur = cur;
		if (!i_run) begin
			next_cur.cnt = i_load;
			next_cur.expired = 1'b0;
		end else if (cur.cnt == '0) begin
			next_cur.expired = 1'b1;
		end else if (i_tick) begin
			next_cur.cnt = cur.cnt - W'(1);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign o_expired = cur.expired;
	assign o_remaining = cur.cnt;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);

	property p_reload;
		// The reset edge itself is left out: the counter still holds its reset value one cycle later
		!i_run && !i_srst |=> (o_remaining == $past(i_load)) && !o_expired;
	endproperty
	a_reload: assert property (p_reload) else $error("timer did not reload when stopped");
endmodule

// File: design/transfer_switch_delay_timers.sv
`timescale 1ns/1ps
// Summary of operation
// - Load-shed delay resets to 0 s and is held within 0 to 15 s.
// - Load-shed output asserts once the load-shed delay has expired.
// - Every delay counts in whole one-second steps.
// - After normal contact closes, cool-down runs, then generator stop is issued.
// - Cool-down delay resets to 60 s and is held within 0 to 3600 s.
// - On restart in utility-generator mode, cool-down runs before stopping generator.
// - Cool-down from running starts only after start delay ended or second source stayed good.
// - Generator-fail delay runs while start command is on and generator not ready.
// - Enabled alarm sets when fail delay expires with generator still not started.
// - Generator alarm clears when replacement or normal supply is in range.
// - Generator-fail delay runs only while external auxiliary power is present.
// - Generator-fail delay resets to 300 s and is held within 15 to 300 s.
// - Generator alarm has an enable, off after reset.
// - On-load test duration is timed; alarm if test still running at expiry.
// - Off-load test duration is timed; alarm if test still running at expiry.
// - Test duration zero means unlimited and is the reset value; limited defaults 30 s.
// - Limited on-load test duration is held within 1 to 1800 s.
// - Limited off-load test duration is held within 1 to 1800 s.
module transfer_switch_delay_timers #(
	parameter int unsigned TICK_CYCLES = ats_delay_pkg::TICK_CYCLES,
	parameter int unsigned SET_W = ats_delay_pkg::SET_W
) (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic i_cfg_wr,
	input wire logic [2:0] i_cfg_addr,
	input wire logic [SET_W-1:0] i_cfg_data,
	input wire logic i_app_ug,
	input wire logic i_shed_start,
	input wire logic i_gen_start_req,
	input wire logic i_start_delay_done,
	input wire logic i_return_delay_active,
	input wire logic i_second_source_ok,
	input wire logic i_normal_closed,
	input wire logic i_gen_ready,
	input wire logic i_aux_power,
	input wire logic i_alt_in_range,
	input wire logic i_normal_in_range,
	input wire logic i_on_test_active,
	input wire logic i_off_test_active,
	input wire logic i_test_alarm_clear,
	output logic o_load_shed,
	output logic o_gen_start_cmd,
	output logic o_cooling,
	output logic o_gen_alarm,
	output logic o_alarm_en,
	output logic o_on_test_alarm,
	output logic o_off_test_alarm
);
	typedef enum logic [3:0] {
		st_restart = 4'b0001,
		st_off = 4'b0010,
		st_running = 4'b0100,
		st_cooling = 4'b1000
	} gen_state_e;

	typedef struct packed {
		gen_state_e st;
		logic gen_cmd;
		logic shed;
		logic gen_alarm;
		logic on_alarm;
		logic off_alarm;
		logic alarm_en;
		logic ret_seen;
		logic ss_ok;
		logic ret_prev;
		logic [SET_W-1:0] shed_set;
		logic [SET_W-1:0] cool_set;
		logic [SET_W-1:0] fail_set;
		logic [SET_W-1:0] on_set;
		logic [SET_W-1:0] off_set;
	} state_s;

	localparam int unsigned NT = ats_delay_pkg::N_TIMERS;

	state_s cur;
	state_s next_cur;
	logic tick;
	logic [NT-1:0] run;
	logic [NT-1:0] expired;
	logic [SET_W-1:0] load [NT];
	logic cool_permit;
	logic fail_set_cond;
	logic on_set_cond;
	logic off_set_cond;

	// Out-of-range writes saturate rather than being dropped, so a setting is always usable
	function automatic logic [SET_W-1:0] clamp(input logic [SET_W-1:0] v, input logic [SET_W-1:0] lo,
			input logic [SET_W-1:0] hi);
		logic [SET_W-1:0] r;
		r = v;
		if (v < lo) begin
			r = lo;
		end else if (v > hi) begin
			r = hi;
		end
		return r;
	endfunction

	function automatic logic [SET_W-1:0] clamp_test(input logic [SET_W-1:0] v);
		logic [SET_W-1:0] r;
		r = v;
		if (v > ats_delay_pkg::TEST_MAX) begin
			r = ats_delay_pkg::TEST_MAX;
		end
		return r;
	endfunction

	second_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.o_tick(tick)
	);

	assign load[ats_delay_pkg::T_SHED] = cur.shed_set;
	assign load[ats_delay_pkg::T_COOL] = cur.cool_set;
	assign load[ats_delay_pkg::T_FAIL] = cur.fail_set;
	assign load[ats_delay_pkg::T_ON_TEST] = cur.on_set;
	assign load[ats_delay_pkg::T_OFF_TEST] = cur.off_set;

	assign run[ats_delay_pkg::T_SHED] = i_shed_start;
	assign run[ats_delay_pkg::T_COOL] = (cur.st == st_cooling);
	// Disabled alarm means the fail delay is not counted at all
	assign run[ats_delay_pkg::T_FAIL] = cur.gen_cmd && (cur.st == st_running) && i_aux_power &&
		!i_gen_ready && cur.alarm_en && !cur.gen_alarm;
	assign run[ats_delay_pkg::T_ON_TEST] = i_on_test_active && (cur.on_set != '0);
	assign run[ats_delay_pkg::T_OFF_TEST] = i_off_test_active && (cur.off_set != '0);

	genvar gi;
	generate
		for (gi = 0; gi < NT; gi++) begin : g_timer
			second_timer #(
				.W(SET_W)
			) u_timer (
				.i_sys_clk(i_sys_clk),
				.i_srst(i_srst),
				.i_tick(tick),
				.i_run(run[gi]),
				.i_load(load[gi]),
				.o_expired(expired[gi]),
				.o_remaining()
			);
		end
	endgenerate

	assign cool_permit = i_start_delay_done || (cur.ret_seen && cur.ss_ok && i_second_source_ok);
	assign fail_set_cond = expired[ats_delay_pkg::T_FAIL] && cur.alarm_en && !i_gen_ready;
	assign on_set_cond = expired[ats_delay_pkg::T_ON_TEST] && i_on_test_active;
	assign off_set_cond = expired[ats_delay_pkg::T_OFF_TEST] && i_off_test_active;

	always_comb begin
		next_cur = cur;

		if (i_cfg_wr) begin
			unique case (i_cfg_addr)
				ats_delay_pkg::ADDR_SHED: begin
					next_cur.shed_set = clamp(i_cfg_data, '0, ats_delay_pkg::SHED_MAX);
				end
				ats_delay_pkg::ADDR_COOL: begin
					next_cur.cool_set = clamp(i_cfg_data, '0, ats_delay_pkg::COOL_MAX);
				end
				ats_delay_pkg::ADDR_FAIL: begin
					next_cur.fail_set = clamp(i_cfg_data, ats_delay_pkg::FAIL_MIN, ats_delay_pkg::FAIL_MAX);
				end
				ats_delay_pkg::ADDR_ON_TEST: begin
					next_cur.on_set = clamp_test(i_cfg_data);
				end
				ats_delay_pkg::ADDR_OFF_TEST: begin
					next_cur.off_set = clamp_test(i_cfg_data);
				end
				ats_delay_pkg::ADDR_ALARM_EN: begin
					next_cur.alarm_en = i_cfg_data[0];
				end
				ats_delay_pkg::ADDR_ON_LIMITED: begin
					next_cur.on_set = ats_delay_pkg::TEST_LIMITED_DEFAULT;
				end
				ats_delay_pkg::ADDR_OFF_LIMITED: begin
					next_cur.off_set = ats_delay_pkg::TEST_LIMITED_DEFAULT;
				end
			endcase
		end

		next_cur.shed = i_shed_start && expired[ats_delay_pkg::T_SHED];

		// Second source must stay good from the first cycle of the return delay onward
		next_cur.ret_prev = i_return_delay_active;
		if (i_return_delay_active && !cur.ret_prev) begin
			next_cur.ret_seen = 1'b1;
			next_cur.ss_ok = i_second_source_ok;
		end else if (i_return_delay_active) begin
			next_cur.ss_ok = cur.ss_ok && i_second_source_ok;
		end

		unique case (cur.st)
			st_restart: begin
				if (i_app_ug) begin
					next_cur.st = st_cooling;
					next_cur.gen_cmd = 1'b1;
				end else begin
					next_cur.st = st_off;
				end
			end
			st_off: begin
				if (i_gen_start_req) begin
					next_cur.st = st_running;
					next_cur.gen_cmd = 1'b1;
					next_cur.ret_seen = 1'b0;
					next_cur.ss_ok = 1'b0;
				end
			end
			st_running: begin
				if (!i_gen_start_req && i_normal_closed && cool_permit) begin
					next_cur.st = st_cooling;
				end
			end
			st_cooling: begin
				if (i_gen_start_req) begin
					next_cur.st = st_running;
				end else if (expired[ats_delay_pkg::T_COOL]) begin
					next_cur.st = st_off;
					next_cur.gen_cmd = 1'b0;
				end
			end
		endcase

		// Set wins over clear so an alarm arriving with the clear is kept
		if (fail_set_cond) begin
			next_cur.gen_alarm = 1'b1;
		end else if (i_alt_in_range || i_normal_in_range) begin
			next_cur.gen_alarm = 1'b0;
		end
		if (on_set_cond) begin
			next_cur.on_alarm = 1'b1;
		end else if (i_test_alarm_clear) begin
			next_cur.on_alarm = 1'b0;
		end
		if (off_set_cond) begin
			next_cur.off_alarm = 1'b1;
		end else if (i_test_alarm_clear) begin
			next_cur.off_alarm = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			cur <= '0;
			cur.st <= st_restart;
			cur.alarm_en <= ats_delay_pkg::ALARM_EN_DEFAULT;
			cur.shed_set <= ats_delay_pkg::SHED_DEFAULT;
			cur.cool_set <= ats_delay_pkg::COOL_DEFAULT;
			cur.fail_set <= ats_delay_pkg::FAIL_DEFAULT;
			cur.on_set <= ats_delay_pkg::TEST_UNLIMITED;
			cur.off_set <= ats_delay_pkg::TEST_UNLIMITED;
		end else begin
			cur <= next_cur;
		end
	end

	assign o_load_shed = cur.shed;
	assign o_gen_start_cmd = cur.gen_cmd;
	assign o_cooling = (cur.st == st_cooling);
	assign o_gen_alarm = cur.gen_alarm;
	assign o_alarm_en = cur.alarm_en;
	assign o_on_test_alarm = cur.on_alarm;
	assign o_off_test_alarm = cur.off_alarm;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);

	property p_shed_range;
		cur.shed_set <= ats_delay_pkg::SHED_MAX;
	endproperty
	a_shed_range: assert property (p_shed_range) else $error("load-shed setting out of range");

	property p_shed_drop;
		!i_shed_start |=> !o_load_shed;
	endproperty
	a_shed_drop: assert property (p_shed_drop) else $error("load shed held without start");

	property p_shed_rise;
		$rose(o_load_shed) |-> $past(expired[ats_delay_pkg::T_SHED]) && $past(i_shed_start);
	endproperty
	a_shed_rise: assert property (p_shed_rise) else $error("load shed rose before delay expiry");

	property p_stop_after_cool;
		$fell(o_gen_start_cmd) |-> $past(o_cooling) && $past(expired[ats_delay_pkg::T_COOL]);
	endproperty
	a_stop_after_cool: assert property (p_stop_after_cool) else $error("generator stopped without cool-down");

	property p_cool_range;
		cur.cool_set <= ats_delay_pkg::COOL_MAX;
	endproperty
	a_cool_range: assert property (p_cool_range) else $error("cool-down setting out of range");

	property p_cool_entry;
		$rose(o_cooling) && $past(cur.st == st_running) |-> $past(cool_permit);
	endproperty
	a_cool_entry: assert property (p_cool_entry) else $error("cool-down began without permission");

	property p_fail_aux;
		!i_aux_power |-> !run[ats_delay_pkg::T_FAIL];
	endproperty
	a_fail_aux: assert property (p_fail_aux) else $error("fail delay ran without auxiliary power");

	property p_alarm_clear;
		(i_alt_in_range || i_normal_in_range) && !fail_set_cond |=> !o_gen_alarm;
	endproperty
	a_alarm_clear: assert property (p_alarm_clear) else $error("generator alarm not cleared");

	property p_alarm_needs_en;
		$rose(o_gen_alarm) |-> $past(cur.alarm_en) && !$past(i_gen_ready);
	endproperty
	a_alarm_needs_en: assert property (p_alarm_needs_en) else $error("generator alarm set while disabled");

	property p_fail_range;
		cur.fail_set >= ats_delay_pkg::FAIL_MIN && cur.fail_set <= ats_delay_pkg::FAIL_MAX;
	endproperty
	a_fail_range: assert property (p_fail_range) else $error("fail setting out of range");

	property p_unlimited;
		(cur.on_set != '0 || !run[ats_delay_pkg::T_ON_TEST]) &&
			(cur.off_set != '0 || !run[ats_delay_pkg::T_OFF_TEST]);
	endproperty
	a_unlimited: assert property (p_unlimited) else $error("unlimited test was timed");

	property p_test_range;
		cur.on_set <= ats_delay_pkg::TEST_MAX && cur.off_set <= ats_delay_pkg::TEST_MAX;
	endproperty
	a_test_range: assert property (p_test_range) else $error("test setting out of range");

	property p_on_alarm_cause;
		$rose(o_on_test_alarm) |-> $past(i_on_test_active) && $past(cur.on_set != '0);
	endproperty
	a_on_alarm_cause: assert property (p_on_alarm_cause) else $error("on-load alarm without timed test");

	property p_off_alarm_cause;
		$rose(o_off_test_alarm) |-> $past(i_off_test_active) && $past(cur.off_set != '0);
	endproperty
	a_off_alarm_cause: assert property (p_off_alarm_cause) else $error("off-load alarm without timed test");

	c_shed: cover property ($rose(o_load_shed));
	c_gen_alarm: cover property ($rose(o_gen_alarm));
	c_cool_stop: cover property ($fell(o_gen_start_cmd));
	c_on_alarm: cover property ($rose(o_on_test_alarm));
endmodule

// File: tb/genset_model.sv
`timescale 1ns/1ps
// Generator set seen from the controller: it comes up only when commanded and able to start.
module genset_model #(
	parameter int unsigned START_CYCLES = 3
) (
	input wire logic i_sys_clk,
	input wire logic i_run_cmd,
	input wire logic i_will_start,
	output logic o_ready
);
	int unsigned cnt = 0;
	initial o_ready = 1'b0;
	// Ready drops at once with the command, as a stopped engine would
	always @(posedge i_sys_clk) begin
		if (!i_run_cmd || !i_will_start) begin
			cnt <= 0;
			o_ready <= 1'b0;
		end else if (cnt >= START_CYCLES) begin
			o_ready <= 1'b1;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// File: tb/transfer_switch_delay_timers_test.sv
`timescale 1ns/1ps
module transfer_switch_delay_timers_test;
	localparam int unsigned T = 4;
	typedef struct {logic [6:0] val; int lo; int hi;} note_s;
	logic i_sys_clk = 1'b0;
	logic i_srst = 1'b1;
	logic i_cfg_wr = 1'b0;
	logic [2:0] i_cfg_addr = 3'h0;
	logic [11:0] i_cfg_data = 12'h000;
	logic i_app_ug = 1'b1;
	logic i_shed_start = 1'b0;
	logic i_gen_start_req = 1'b0;
	logic i_start_delay_done = 1'b0;
	logic i_return_delay_active = 1'b0;
	logic i_second_source_ok = 1'b0;
	logic i_normal_closed = 1'b0;
	logic i_aux_power = 1'b0;
	logic i_alt_in_range = 1'b0;
	logic i_normal_in_range = 1'b0;
	logic i_on_test_active = 1'b0;
	logic i_off_test_active = 1'b0;
	logic i_test_alarm_clear = 1'b0;
	logic will_start = 1'b0;
	logic gen_ready;
	logic o_load_shed, o_gen_start_cmd, o_cooling, o_gen_alarm, o_alarm_en, o_on_test_alarm, o_off_test_alarm;
	logic [6:0] outs;
	logic [6:0] prev = 7'h00;
	logic [6:0] e = 7'h00;
	int cyc = 0;
	int mismatches = 0;
	int n_compared = 0;
	int seed = 8;
	int d;
	note_s q[$];
	note_s n;

	always #20 i_sys_clk = ~i_sys_clk;
	always @(negedge i_sys_clk) cyc++;
	assign outs = {o_load_shed, o_gen_start_cmd, o_cooling, o_gen_alarm, o_alarm_en, o_on_test_alarm, o_off_test_alarm};

	transfer_switch_delay_timers #(.TICK_CYCLES(T), .SET_W(12)) transfer_switch_delay_timers_i (
		.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_cfg_wr(i_cfg_wr), .i_cfg_addr(i_cfg_addr),
		.i_cfg_data(i_cfg_data), .i_app_ug(i_app_ug), .i_shed_start(i_shed_start),
		.i_gen_start_req(i_gen_start_req), .i_start_delay_done(i_start_delay_done),
		.i_return_delay_active(i_return_delay_active), .i_second_source_ok(i_second_source_ok),
		.i_normal_closed(i_normal_closed), .i_gen_ready(gen_ready), .i_aux_power(i_aux_power),
		.i_alt_in_range(i_alt_in_range), .i_normal_in_range(i_normal_in_range),
		.i_on_test_active(i_on_test_active), .i_off_test_active(i_off_test_active),
		.i_test_alarm_clear(i_test_alarm_clear), .o_load_shed(o_load_shed), .o_gen_start_cmd(o_gen_start_cmd),
		.o_cooling(o_cooling), .o_gen_alarm(o_gen_alarm), .o_alarm_en(o_alarm_en),
		.o_on_test_alarm(o_on_test_alarm), .o_off_test_alarm(o_off_test_alarm));

	genset_model #(.START_CYCLES(3)) genset_model_i (
		.i_sys_clk(i_sys_clk), .i_run_cmd(o_gen_start_cmd), .i_will_start(will_start), .o_ready(gen_ready));

	task automatic expect_out(input logic [6:0] v, input int lo, input int hi);
		e = v;
		q.push_back('{v, cyc + lo, cyc + hi});
	endtask

	// Every note must have been met by now; any change without a note is caught by the watcher
	task automatic settle(input int cycles);
		repeat (cycles) @(posedge i_sys_clk);
		n_compared++;
		if (q.size() != 0) begin
			$display("BAD pending_changes expected 0 seen %0d", q.size());
			mismatches++;
			q.delete();
		end
	endtask

	task automatic cfg(input logic [2:0] a, input logic [11:0] v);
		@(posedge i_sys_clk);
		i_cfg_wr <= 1'b1;
		i_cfg_addr <= a;
		i_cfg_data <= v;
		@(posedge i_sys_clk);
		i_cfg_wr <= 1'b0;
	endtask

	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge i_sys_clk) begin
		#1;
		if (!i_srst && outs !== prev) begin
			n_compared++;
			if (q.size() == 0) begin
				$display("BAD outputs expected %b seen %b at cycle %0d", prev, outs, cyc);
				mismatches++;
			end else begin
				n = q.pop_front();
				if (outs !== n.val || cyc < n.lo || cyc > n.hi) begin
					$display("BAD outputs expected %b in %0d..%0d seen %b at %0d", n.val, n.lo, n.hi, outs, cyc);
					mismatches++;
				end
			end
		end
		prev = outs;
	end

	initial begin
		repeat (20000) @(posedge i_sys_clk);
		mismatches++;
		complete_run();
	end

	initial begin
		repeat (16) @(posedge i_sys_clk);
		i_srst <= 1'b0;
		// Command and cool-down state come up at the same edge after release
		expect_out(7'b0110000, 1, 3);
		expect_out(7'b0000000, 59 * T, 60 * T + 6);
		settle(60 * T + 20);
		@(posedge i_sys_clk);
		i_app_ug <= 1'b0;
		cfg(ats_delay_pkg::ADDR_ALARM_EN, 12'h001);
		expect_out(7'b0000100, 0, 2);
		settle(5);
		// Shed delay: default zero, then one random setting and one above the top of its range
		@(posedge i_sys_clk);
		i_shed_start <= 1'b1;
		expect_out(e | 7'b1000000, 1, 3);
		settle(6);
		i_shed_start <= 1'b0;
		expect_out(e & 7'b0111111, 1, 3);
		settle(4);
		for (int k = 0; k < 2; k++) begin
			d = (k == 0) ? (($random(seed) & 32'hF) | 1) : 15;
			cfg(ats_delay_pkg::ADDR_SHED, (k == 0) ? d[11:0] : 12'h014);
			@(posedge i_sys_clk);
			i_shed_start <= 1'b1;
			expect_out(e | 7'b1000000, (d - 1) * T + 2, d * T + 4);
			settle(d * T + 8);
			i_shed_start <= 1'b0;
			expect_out(e & 7'b0111111, 1, 3);
			settle(4);
		end
		// Fail delay below its range saturates to the minimum; no count without auxiliary power
		cfg(ats_delay_pkg::ADDR_FAIL, 12'h005);
		@(posedge i_sys_clk);
		i_gen_start_req <= 1'b1;
		expect_out(e | 7'b0100000, 1, 3);
		settle(100);
		i_aux_power <= 1'b1;
		expect_out(e | 7'b0001000, 14 * T + 2, 15 * T + 6);
		settle(15 * T + 10);
		i_alt_in_range <= 1'b1;
		will_start <= 1'b1;
		expect_out(e & 7'b1110111, 1, 3);
		@(posedge i_sys_clk);
		i_alt_in_range <= 1'b0;
		settle(20 * T);
		// Cool-down waits for the start delay, then stops the generator
		cfg(ats_delay_pkg::ADDR_COOL, 12'h003);
		@(posedge i_sys_clk);
		i_gen_start_req <= 1'b0;
		i_normal_closed <= 1'b1;
		settle(20);
		i_start_delay_done <= 1'b1;
		expect_out(e | 7'b0010000, 1, 3);
		expect_out(e & 7'b1001111, 2 * T + 2, 3 * T + 7);
		settle(3 * T + 10);
		i_normal_closed <= 1'b0;
		i_start_delay_done <= 1'b0;
		will_start <= 1'b0;
		// Second permission path: second source good since the return delay began
		i_gen_start_req <= 1'b1;
		expect_out(e | 7'b0100000, 1, 3);
		settle(4);
		i_gen_start_req <= 1'b0;
		i_normal_closed <= 1'b1;
		i_return_delay_active <= 1'b1;
		i_second_source_ok <= 1'b1;
		expect_out(e | 7'b0010000, 2, 4);
		expect_out(e & 7'b1001111, 2 * T + 3, 3 * T + 8);
		settle(3 * T + 10);
		i_normal_closed <= 1'b0;
		i_return_delay_active <= 1'b0;
		i_second_source_ok <= 1'b0;
		// Tests: unlimited by default, limited default, and a limit above range saturating
		i_on_test_active <= 1'b1;
		settle(60);
		i_on_test_active <= 1'b0;
		cfg(ats_delay_pkg::ADDR_ON_LIMITED, 12'h000);
		@(posedge i_sys_clk);
		i_on_test_active <= 1'b1;
		expect_out(e | 7'b0000010, 29 * T + 2, 30 * T + 4);
		settle(30 * T + 8);
		i_test_alarm_clear <= 1'b1;
		i_on_test_active <= 1'b0;
		expect_out(e & 7'b1111101, 1, 3);
		@(posedge i_sys_clk);
		i_test_alarm_clear <= 1'b0;
		cfg(ats_delay_pkg::ADDR_OFF_TEST, 12'hFA0);
		@(posedge i_sys_clk);
		i_off_test_active <= 1'b1;
		expect_out(e | 7'b0000001, 1799 * T + 2, 1800 * T + 4);
		settle(1800 * T + 8);
		// The test must end with the clear, or the still-pending expiry wins over it
		i_test_alarm_clear <= 1'b1;
		i_off_test_active <= 1'b0;
		expect_out(e & 7'b1111110, 1, 3);
		@(posedge i_sys_clk);
		i_test_alarm_clear <= 1'b0;
		settle(5);
		complete_run();
	end
endmodule
